// >>> pkg/adp_pkg.sv
package adp_pkg;
   // Host serial clock timing
   localparam int         REF_PERIOD_NS = 10;
   localparam int         SCLK_HALF_NS  = 80;
   localparam int         HALF_CYC      = (SCLK_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
   localparam logic [2:0] HALF_LAST     = 3'(HALF_CYC - 1);
   localparam logic [2:0] BIT_LAST      = 3'h7;
   // Communications byte layout
   localparam int         CMD_READ_POS  = 6;
   localparam logic [2:0] ADDR_PORT     = 3'h0;
   localparam logic [2:0] ADDR_MODE     = 3'h1;
   localparam logic [2:0] ADDR_STAT     = 3'h2;
   localparam logic [2:0] ADDR_CHAN     = 3'h3;
   // Port register fields
   localparam int         PA_DATA_POS   = 0;
   localparam int         PB_DATA_POS   = 1;
   localparam int         PA_DIR_POS    = 2;
   localparam int         PB_DIR_POS    = 3;
   localparam int         SYNC_EN_POS   = 4;
   localparam int         RDY_FN_POS    = 5;
   // Mode register fields
   localparam int         CLK_DIS_POS   = 0;
   localparam int         CAL_MODE_POS  = 1;
   // Status register fields and register reset values
   localparam int         STAT_RDY_POS  = 0;
   localparam int         STAT_PB_POS   = 1;
   localparam logic [7:0] PORT_RST      = 8'h0C;
   localparam logic [7:0] MODE_RST      = 8'h00;

   typedef enum logic [1:0] {PH_CMD, PH_WRITE, PH_READ} adp_phase_type;
   typedef enum logic [2:0] {H_IDLE, H_SELECT, H_LOW, H_HIGH, H_GAP} adp_hstate_type;
endpackage

// >>> pkg/adp_link_if.sv
`timescale 1ns/100ps
interface adp_link_if;
   logic sclk;
   logic cs_drv_n;
   logic cs_oe;
   logic cs_n;
   logic din;
   logic dout;
   logic dout_oe;
   logic dout_lvl;
   logic rdy_n;
   logic dev_rst_n;
   logic mclk_in;
   logic mclk_out;
   logic pa_out;
   logic pa_oe;
   logic pa_ext;
   logic pa_lvl;
   logic pb_out;
   logic pb_oe;
   logic pb_ext;
   logic pb_lvl;

   // Internal pull-up when the host lets go of chip select
   assign cs_n     = cs_oe ? cs_drv_n : 1'b1;
   assign dout_lvl = dout_oe ? dout : 1'b0;
   assign pa_lvl   = pa_oe ? pa_out : pa_ext;
   assign pb_lvl   = pb_oe ? pb_out : pb_ext;

   modport dev (
      input  sclk, cs_n, din, dev_rst_n, mclk_in, pa_lvl, pb_lvl,
      output dout, dout_oe, rdy_n, mclk_out, pa_out, pa_oe, pb_out, pb_oe
   );
   modport host (
      output sclk, cs_drv_n, cs_oe, din, dev_rst_n, mclk_in,
      input  dout_lvl, rdy_n, mclk_out
   );
endinterface

// >>> core/adp_sync2.sv
`timescale 1ns/100ps
module adp_sync2
   import adp_pkg::*;
#(
   parameter int W = 1
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] hold;
   } adp_sync_type;

   adp_sync_type st_ff;
   adp_sync_type nxt_st;

   always_comb
   begin
      nxt_st.meta = d;
      nxt_st.hold = st_ff.meta;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign q = st_ff.hold;
endmodule // adp_sync2

// >>> core/adp_host.sv
`timescale 1ns/100ps
module adp_host
   import adp_pkg::*;
(
   adp_link_if.host        lnk,
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       use_cs,
   input  wire logic       dev_reset_req,
   input  wire logic       cmd_valid,
   input  wire logic       cmd_read,
   input  wire logic [2:0] cmd_addr,
   input  wire logic [7:0] cmd_wdata,
   output logic            cmd_ready,
   output logic            rsp_valid,
   output logic      [7:0] rsp_rdata,
   output logic            dev_ready
);
   typedef struct packed {
      adp_hstate_type st;
      logic [2:0]     div;
      logic [2:0]     bitn;
      logic           second;
      logic           rd;
      logic [7:0]     tx;
      logic [7:0]     data;
      logic [7:0]     rx;
      logic           sclk;
      logic           cs_n;
      logic           cs_oe;
      logic           din;
      logic           mclk;
      logic           pin_rst_n;
      logic           ready;
      logic           rsp_v;
      logic [7:0]     rsp_d;
      logic           dev_rdy;
   } adp_host_type;

   adp_host_type h_ff;
   adp_host_type nxt_h;

   // Serial clock resets to its idle high level, so releasing reset never makes a false rising edge
   localparam adp_host_type HOST_RST = '{st: H_IDLE, sclk: 1'b1, default: '0};
   logic         dout_s;
   logic         rdy_s_n;
   logic         div_end;

   adp_sync2 #(.W(2)) u_sync (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .d     ({lnk.dout_lvl, lnk.rdy_n}),
      .q     ({dout_s, rdy_s_n})
   );

   assign div_end = (h_ff.div == HALF_LAST);

   always_comb
   begin
      nxt_h           = h_ff;
      nxt_h.mclk      = ~h_ff.mclk;
      nxt_h.pin_rst_n = ~dev_reset_req;
      nxt_h.rsp_v     = 1'b0;
      nxt_h.dev_rdy   = ~rdy_s_n;
      nxt_h.div       = div_end ? 3'h0 : h_ff.div + 3'h1;
      case (h_ff.st)
         H_IDLE:
         begin
            nxt_h.div   = 3'h0;
            nxt_h.sclk  = 1'b1;
            nxt_h.cs_n  = 1'b0;
            nxt_h.cs_oe = ~use_cs;
            nxt_h.ready = 1'b1;
            if (cmd_valid && h_ff.ready)
            begin
               nxt_h.ready                = 1'b0;
               nxt_h.rd                   = cmd_read;
               nxt_h.tx                   = 8'(cmd_addr);
               nxt_h.tx[CMD_READ_POS]     = cmd_read;
               nxt_h.data                 = cmd_wdata;
               nxt_h.second               = 1'b0;
               nxt_h.cs_oe                = 1'b1;
               nxt_h.st                   = H_SELECT;
            end
         end
         H_SELECT:
         begin
            if (div_end)
            begin
               nxt_h.sclk = 1'b0;
               nxt_h.din  = h_ff.tx[7];
               nxt_h.bitn = 3'h0;
               nxt_h.st   = H_LOW;
            end
         end
         H_LOW:
         begin
            if (div_end)
            begin
               nxt_h.sclk = 1'b1;
               nxt_h.st   = H_HIGH;
               if (h_ff.second && h_ff.rd)
                  nxt_h.rx = {h_ff.rx[6:0], dout_s};
            end
         end
         H_HIGH:
         begin
            if (div_end)
            begin
               if (h_ff.bitn == BIT_LAST)
               begin
                  nxt_h.st = H_GAP;
                  if (use_cs)
                     nxt_h.cs_oe = 1'b0;
               end
               else
               begin
                  nxt_h.sclk = 1'b0;
                  nxt_h.bitn = h_ff.bitn + 3'h1;
                  nxt_h.tx   = {h_ff.tx[6:0], 1'b0};
                  nxt_h.din  = h_ff.tx[6];
                  nxt_h.st   = H_LOW;
               end
            end
         end
         H_GAP:
         begin
            if (div_end)
            begin
               if (!h_ff.second)
               begin
                  nxt_h.second = 1'b1;
                  nxt_h.tx     = h_ff.data;
                  nxt_h.cs_oe  = 1'b1;
                  nxt_h.st     = H_SELECT;
               end
               else
               begin
                  nxt_h.rsp_v = 1'b1;
                  nxt_h.rsp_d = h_ff.rx;
                  nxt_h.st    = H_IDLE;
               end
            end
         end
         default:
            nxt_h.st = H_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         h_ff <= HOST_RST;
      else
         h_ff <= nxt_h;
   end

   assign lnk.sclk      = h_ff.sclk;
   assign lnk.cs_drv_n  = h_ff.cs_n;
   assign lnk.cs_oe     = h_ff.cs_oe;
   assign lnk.din       = h_ff.din;
   assign lnk.mclk_in   = h_ff.mclk;
   assign lnk.dev_rst_n = h_ff.pin_rst_n;
   assign cmd_ready     = h_ff.ready;
   assign rsp_valid     = h_ff.rsp_v;
   assign rsp_rdata     = h_ff.rsp_d;
   assign dev_ready     = h_ff.dev_rdy;
endmodule // adp_host

// >>> core/adp_dev.sv
`timescale 1ns/100ps
module adp_dev
   import adp_pkg::*;
(
   adp_link_if.dev         lnk,
   input  wire logic       ref_clk,
   input  wire logic [7:0] chan_unread,
   input  wire logic       cal_done,
   output logic            cal_mode,
   output logic            common_ref_sel,
   output logic            sync_hold
);
   // Link-side state, clocked by the host serial clock
   typedef struct packed {
      adp_phase_type phase;
      logic [2:0]    cnt;
      logic [7:0]    sh_in;
      logic [7:0]    sh_out;
      logic [2:0]    addr;
      logic          oe;
      logic [7:0]    port;
      logic [7:0]    mode;
   } adp_lnk_type;

   // Core-side state, clocked by ref_clk
   typedef struct packed {
      logic rdy_n;
      logic cal;
      logic com_ref;
      logic hold;
   } adp_core_type;

   localparam adp_lnk_type LNK_RST = '{
      phase  : PH_CMD,
      cnt    : 3'h0,
      sh_in  : 8'h00,
      sh_out : 8'h00,
      addr   : 3'h0,
      oe     : 1'b0,
      port   : PORT_RST,
      mode   : MODE_RST
   };

   adp_lnk_type  l_ff;
   adp_lnk_type  nxt_l;
   adp_core_type c_ff;
   adp_core_type nxt_c;
   logic         rst_n;
   logic [7:0]   sh;
   logic [7:0]   unread_s;
   logic         rdy_s_n;
   logic         pb_s;
   logic         c_pa_dir;
   logic         c_sync_en;
   logic         c_rdy_fn;
   logic         c_cal;
   logic         c_pb;

   // Whole part is held while the reset pin is low
   assign rst_n = lnk.dev_rst_n;

   // Register read mux feeding the output shifter
   function automatic logic [7:0] rd_mux(
      input logic [2:0] a,
      input logic [7:0] port,
      input logic [7:0] mode,
      input logic       pb,
      input logic       rdy_n,
      input logic [7:0] unread
   );
      logic [7:0] v;
      v = 8'h00;
      if (a == ADDR_PORT)
      begin
         v = port;
         if (port[PB_DIR_POS] || port[SYNC_EN_POS])
            v[PB_DATA_POS] = pb;
      end
      else if (a == ADDR_MODE)
         v = mode;
      else if (a == ADDR_STAT)
      begin
         v[STAT_RDY_POS] = rdy_n;
         v[STAT_PB_POS]  = pb;
      end
      else if (a == ADDR_CHAN)
         v = unread;
      return v;
   endfunction

   adp_sync2 #(.W(10)) u_sync_lnk (
      .clk   (lnk.sclk),
      .rst_n (rst_n),
      .d     ({chan_unread, c_ff.rdy_n, lnk.pb_lvl}),
      .q     ({unread_s, rdy_s_n, pb_s})
   );

   adp_sync2 #(.W(5)) u_sync_core (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .d     ({l_ff.port[PA_DIR_POS], l_ff.port[SYNC_EN_POS], l_ff.port[RDY_FN_POS],
               l_ff.mode[CAL_MODE_POS], lnk.pb_lvl}),
      .q     ({c_pa_dir, c_sync_en, c_rdy_fn, c_cal, c_pb})
   );

   // Serial port: command byte, then one data byte
   always_comb
   begin
      nxt_l = l_ff;
      sh    = {l_ff.sh_in[6:0], lnk.din};
      if (!lnk.cs_n)
      begin
         nxt_l.sh_in = sh;
         nxt_l.cnt   = l_ff.cnt + 3'h1;
         if (l_ff.phase == PH_READ)
            nxt_l.sh_out = {l_ff.sh_out[6:0], 1'b0};
         if (l_ff.cnt == BIT_LAST)
         begin
            case (l_ff.phase)
               PH_CMD:
               begin
                  nxt_l.addr = sh[2:0];
                  if (sh[CMD_READ_POS])
                  begin
                     nxt_l.phase  = PH_READ;
                     nxt_l.sh_out = rd_mux(sh[2:0], l_ff.port, l_ff.mode, pb_s,
                                           rdy_s_n, unread_s);
                     nxt_l.oe     = 1'b1;
                  end
                  else
                     nxt_l.phase = PH_WRITE;
               end
               PH_WRITE:
               begin
                  nxt_l.phase = PH_CMD;
                  if (l_ff.addr == ADDR_PORT)
                     nxt_l.port = sh;
                  else if (l_ff.addr == ADDR_MODE)
                     nxt_l.mode = sh;
               end
               default:
               begin
                  nxt_l.phase = PH_CMD;
                  nxt_l.oe    = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge lnk.sclk or negedge rst_n)
   begin
      if (!rst_n)
         l_ff <= LNK_RST;
      else
         l_ff <= nxt_l;
   end

   // Ready pin and core-side controls
   always_comb
   begin
      nxt_c         = c_ff;
      nxt_c.cal     = c_cal;
      nxt_c.com_ref = c_pa_dir;
      nxt_c.hold    = c_sync_en & ~c_pb;
      if (c_cal)
         nxt_c.rdy_n = ~cal_done;
      else if (c_rdy_fn)
         nxt_c.rdy_n = ~(&chan_unread);
      else
         nxt_c.rdy_n = ~(|chan_unread);
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         c_ff <= '{rdy_n: 1'b1, cal: 1'b0, com_ref: 1'b0, hold: 1'b0};
      else
         c_ff <= nxt_c;
   end

   // Output shifter releases the line once deselected
   assign lnk.dout     = l_ff.sh_out[7];
   assign lnk.dout_oe  = l_ff.oe & ~lnk.cs_n;
   assign lnk.pa_out   = l_ff.port[PA_DATA_POS];
   assign lnk.pa_oe    = ~l_ff.port[PA_DIR_POS];
   assign lnk.pb_out   = l_ff.port[PB_DATA_POS];
   assign lnk.pb_oe    = ~l_ff.port[PB_DIR_POS] & ~l_ff.port[SYNC_EN_POS];
   assign lnk.mclk_out = ~lnk.mclk_in & ~l_ff.mode[CLK_DIS_POS];
   assign lnk.rdy_n    = c_ff.rdy_n;
   assign cal_mode       = c_ff.cal;
   assign common_ref_sel = c_ff.com_ref;
   assign sync_hold      = c_ff.hold;
endmodule // adp_dev

// >>> tb/adp_checker.sv
`timescale 1ns/100ps
module adp_checker
   import adp_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic dev_rst_n,
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic din,
   input  wire logic dout_oe,
   input  wire logic mclk_in,
   input  wire logic mclk_out,
   input  wire logic pa_oe,
   input  wire logic pb_oe,
   input  wire logic rdy_n
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!dev_rst_n);

   sequence s_rise;
      $rose(sclk);
   endsequence
   sequence s_fall;
      $fell(sclk);
   endsequence

   a_sclk_high: assert property (s_rise |-> sclk [*8]) else $error("sclk high phase short");
   a_sclk_low: assert property (s_fall |-> !sclk [*8]) else $error("sclk low phase short");
   a_din_hold: assert property (s_rise |=> $stable(din) [*3]) else $error("din moved after rise");
   a_cs_rise_high: assert property ($rose(cs_n) |-> sclk) else $error("select rose mid byte");
   a_cs_fall_high: assert property ($fell(cs_n) |-> sclk) else $error("select fell mid byte");
   a_dout_deselect: assert property (cs_n |-> !dout_oe) else $error("dout driven unselected");
   a_dout_launch: assert property ($rose(dout_oe) && !$fell(cs_n) |-> s_rise) else $error("dout off edge");
   a_mclk_inverted: assert property (mclk_out |-> !mclk_in) else $error("clock out not inverted");
   a_reset_defaults: assert property ($rose(dev_rst_n) |-> !pa_oe && !pb_oe && rdy_n)
      else $error("pins not at defaults");
endmodule // adp_checker

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
   import adp_pkg::*;
   logic       ref_clk       = 1'b0;
   logic       rst_n         = 1'b0;
   logic       use_cs        = 1'b1;
   logic       dev_reset_req = 1'b0;
   logic       cmd_valid     = 1'b0;
   logic       cmd_read      = 1'b0;
   logic [2:0] cmd_addr      = 3'h0;
   logic [7:0] cmd_wdata     = 8'h00;
   logic [7:0] chan_unread   = 8'h00;
   logic       cal_done      = 1'b0;
   logic       cmd_ready;
   logic       rsp_valid;
   logic       dev_ready;
   logic       cal_mode;
   logic       common_ref_sel;
   logic       sync_hold;
   logic [7:0] rsp_rdata;
   logic [7:0] rd_q;
   logic [7:0] pv;
   int         n_mismatch    = 0;
   int         n_compared    = 0;

   adp_link_if lnk ();
   adp_host i_adp_host (.lnk(lnk), .ref_clk(ref_clk), .rst_n(rst_n), .use_cs(use_cs),
      .dev_reset_req(dev_reset_req), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .dev_ready(dev_ready));
   adp_dev i_adp_dev (.lnk(lnk), .ref_clk(ref_clk), .chan_unread(chan_unread), .cal_done(cal_done),
      .cal_mode(cal_mode), .common_ref_sel(common_ref_sel), .sync_hold(sync_hold));
   adp_checker i_adp_checker (.ref_clk(ref_clk), .dev_rst_n(lnk.dev_rst_n), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
      .din(lnk.din), .dout_oe(lnk.dout_oe), .mclk_in(lnk.mclk_in), .mclk_out(lnk.mclk_out),
      .pa_oe(lnk.pa_oe), .pb_oe(lnk.pb_oe), .rdy_n(lnk.rdy_n));

   // Pin view: pa_oe pa_lvl pb_oe pb_lvl common_ref sync rdy_n cal
   assign pv = {lnk.pa_oe, lnk.pa_lvl, lnk.pb_oe, lnk.pb_lvl, common_ref_sel, sync_hold, lnk.rdy_n, cal_mode};

   always #5 ref_clk = ~ref_clk;

   task stop_test;
      if (n_mismatch == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task xfer(input logic rd, input logic [2:0] a, input logic [7:0] wd);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 400)
      begin
         @(negedge ref_clk);
         n++;
      end
      cmd_valid = 1'b1;
      cmd_read  = rd;
      cmd_addr  = a;
      cmd_wdata = wd;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 400)
      begin
         @(negedge ref_clk);
         n++;
      end
      chk(16'(n), 16'h0120);
      rd_q = rsp_rdata;
   endtask

   task wr(input logic [2:0] a, input logic [7:0] d);
      xfer(1'b0, a, d);
      repeat (4) @(negedge ref_clk);
   endtask

   task rdc(input logic [2:0] a, input logic [7:0] e);
      xfer(1'b1, a, 8'hA5);
      chk({8'h00, rd_q}, {8'h00, e});
   endtask

   task t_defaults;
      chk({15'h0000, lnk.cs_n}, 16'h0001);
      chk({8'h00, pv}, 16'h001A);
      rdc(3'h0, 8'h0E);
   endtask

   task t_port;
      wr(3'h0, 8'h01);
      chk({8'h00, pv}, 16'h00E2);
      rdc(3'h0, 8'h01);
      wr(3'h0, 8'h06);
      chk({8'h00, pv}, 16'h003A);
      wr(3'h5, 8'hFF);
      wr(3'h2, 8'hFF);
      rdc(3'h5, 8'h00);
      rdc(3'h0, 8'h06);
   endtask

   task t_sync;
      lnk.pb_ext = 1'b0;
      wr(3'h0, 8'h18);
      chk({8'h00, pv}, 16'h0086);
      lnk.pb_ext = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk({8'h00, pv}, 16'h0092);
   endtask

   task t_ready;
      wr(3'h0, 8'h0C);
      chan_unread = 8'h01;
      repeat (4) @(negedge ref_clk);
      chk({8'h00, pv}, 16'h0018);
      repeat (4) @(negedge ref_clk);
      chk({15'h0000, dev_ready}, 16'h0001);
      wr(3'h0, 8'h2C);
      chk({8'h00, pv}, 16'h001A);
      chan_unread = 8'hFF;
      repeat (4) @(negedge ref_clk);
      chk({8'h00, pv}, 16'h0018);
      rdc(3'h2, 8'h02);
      rdc(3'h3, 8'hFF);
      chan_unread = 8'h00;
   endtask

   task t_cal;
      wr(3'h1, 8'h02);
      chk({8'h00, pv}, 16'h001B);
      cal_done = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk({8'h00, pv}, 16'h0019);
      rdc(3'h1, 8'h02);
      cal_done = 1'b0;
   endtask

   task t_clk_out;
      int n;
      wr(3'h1, 8'h01);
      n = 0;
      repeat (20)
      begin
         @(negedge ref_clk);
         n += int'(lnk.mclk_out === 1'b1);
      end
      chk(16'(n), 16'h0000);
      wr(3'h1, 8'h00);
      n = 0;
      repeat (20)
      begin
         @(negedge ref_clk);
         n += int'(lnk.mclk_out === 1'b1);
      end
      chk(16'(n), 16'h000A);
   endtask

   task t_dev_reset;
      wr(3'h0, 8'h01);
      dev_reset_req = 1'b1;
      repeat (4) @(negedge ref_clk);
      dev_reset_req = 1'b0;
      repeat (8) @(negedge ref_clk);
      chk({8'h00, pv}, 16'h001A);
      rdc(3'h0, 8'h0E);
   endtask

   task t_three_wire;
      rst_n  = 1'b0;
      use_cs = 1'b0;
      repeat (2) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (8) @(negedge ref_clk);
      chk({15'h0000, lnk.cs_n}, 16'h0000);
      wr(3'h0, 8'h01);
      rdc(3'h0, 8'h01);
   endtask

   initial
   begin
      #300000;
      n_mismatch++;
      stop_test;
   end

   initial
   begin
      lnk.pa_ext = 1'b0;
      lnk.pb_ext = 1'b1;
      repeat (2) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (8) @(negedge ref_clk);
      t_defaults;
      t_port;
      t_sync;
      t_ready;
      t_cal;
      t_clk_out;
      t_dev_reset;
      t_three_wire;
      stop_test;
   end
endmodule // tb
